/* include/embg_pkg.sv */
// types shared by the external memory bus and grant block
`default_nettype none
package embg_pkg;
   typedef enum logic [2:0]
   {
      EMBG_IDLE    = 3'h0,
      EMBG_SETUP   = 3'h1,
      EMBG_STROBE  = 3'h3,
      EMBG_HOLD    = 3'h2,
      EMBG_RELEASE = 3'h6,
      EMBG_GRANTED = 3'h7,
      EMBG_RESUME  = 3'h5
   } embg_state_t;

   typedef struct packed
   {
      logic        write;
      logic [2:0]  space;
      logic [13:0] addr;
      logic [23:0] wdata;
   } embg_req_t;
endpackage
`default_nettype wire

/* include/embg_regs.svh */
// timing and encoding constants for the external memory bus and grant block
`ifndef EMBG_REGS_SVH
`define EMBG_REGS_SVH
`define EMBG_ADDR_W        14
`define EMBG_DATA_W        24
`define EMBG_WAIT_W        3
`define EMBG_NUM_SPACES    5
`define EMBG_NUM_IRQ       6
`define EMBG_NUM_PF        8
`define EMBG_SEL_IDLE      5'h1f
`define EMBG_PHASE_W       2
`define EMBG_PH_QTR        2'h1
`define EMBG_PH_HALF       2'h2
`define EMBG_PH_3QTR       2'h3
`define EMBG_PH_ZERO       2'h0
`endif

/* rtl/embg_bus.sv */
// external memory strobe sequencer, bus grant handshake and input synchronisers
//
// Function
// - Interrupt and flag inputs are recognised at the third enabled clock edge after they change: two synchroniser stages, then an output register.
// - The bus request is asynchronous and is synchronised before it is recognised.
// - On granting, selects and strobes are released first and grant goes low afterwards.
// - On ending a grant, grant goes high first and selects and strobes are driven afterwards.
// - Grant-hung is asserted while the bus is granted and the core or byte DMA engine needs the bus.
// - Address and space select are set before the read strobe falls and held after it rises.
// - Write data is valid from strobe fall to after strobe rise, lengthened by the wait states.
// - Data is driven on the same edge as the write strobe falls and released before the next strobe falls.
`timescale 1ns/100ps
`default_nettype none
`include "embg_regs.svh"
module embg_bus
   import embg_pkg::*;
#(
   parameter int WAIT_W = `EMBG_WAIT_W
)
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          clk_en,
   input  wire logic                          req_valid,
   input  wire embg_req_t                     req,
   input  wire logic [`EMBG_NUM_SPACES*WAIT_W-1:0] wait_states,
   input  wire logic                          byte_dma_engine_need,
   input  wire logic                          bus_req_n,
   input  wire logic [`EMBG_NUM_IRQ-1:0]      ext_irq_lines,
   input  wire logic                          flag_input,
   input  wire logic [`EMBG_NUM_PF-1:0]       prog_flag_pins,
   input  wire logic [`EMBG_DATA_W-1:0]       data_in,
   output logic                               req_ready,
   output logic                               rdata_valid,
   output logic [`EMBG_DATA_W-1:0]            rdata,
   output logic [`EMBG_ADDR_W-1:0]            addr_out,
   output logic [`EMBG_NUM_SPACES-1:0]        mem_space_selects,
   output logic                               rd_n,
   output logic                               wr_n,
   output logic                               ctrl_oe,
   output logic [`EMBG_DATA_W-1:0]            data_out,
   output logic                               data_oe,
   output logic                               bus_grant_n,
   output logic                               bus_grant_hung_n,
   output logic [`EMBG_NUM_IRQ-1:0]           irq_sync,
   output logic                               flag_sync,
   output logic [`EMBG_NUM_PF-1:0]            pf_sync
);

   // two-stage synchronisers; first stage is read only by the second
   localparam int SW = `EMBG_NUM_IRQ + 1 + `EMBG_NUM_PF + 1;
   logic [SW-1:0] s1_reg, s1_next, s2_reg, s2_next;

   always_comb
   begin
      s1_next = s1_reg;
      s2_next = s2_reg;
      if (clk_en)
      begin
         s1_next = {~bus_req_n, ext_irq_lines, flag_input, prog_flag_pins};
         s2_next = s1_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   // recognised lines are registered outputs, one cycle after the second stage
   logic [`EMBG_NUM_IRQ-1:0] irq_next;
   logic                     flag_next;
   logic [`EMBG_NUM_PF-1:0]  pf_next;
   logic                     breq_reg, breq_next;

   always_comb
   begin
      {breq_next, irq_next, flag_next, pf_next} = {breq_reg, irq_sync, flag_sync, pf_sync};
      if (clk_en)
         {breq_next, irq_next, flag_next, pf_next} = s2_reg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         breq_reg  <= 1'b0;
         irq_sync  <= '0;
         flag_sync <= 1'b0;
         pf_sync   <= '0;
      end
      else
      begin
         breq_reg  <= breq_next;
         irq_sync  <= irq_next;
         flag_sync <= flag_next;
         pf_sync   <= pf_next;
      end
   end

   // bus sequencer; each memory cycle moves through setup, strobe and hold phases
   embg_state_t          st_reg, st_next;
   embg_req_t            cur_reg, cur_next;
   logic [WAIT_W:0]      cnt_reg, cnt_next;
   logic                 rd_n_next, wr_n_next, ctrl_oe_next, data_oe_next;
   logic                 grant_n_next, hung_n_next, ready_next, rv_next;
   logic [`EMBG_DATA_W-1:0]     rdata_next;
   logic [`EMBG_NUM_SPACES-1:0] sel_next;
   logic [WAIT_W-1:0]    ws;

   always_comb
   begin
      st_next      = st_reg;
      cur_next     = cur_reg;
      cnt_next     = cnt_reg;
      rd_n_next    = rd_n;
      wr_n_next    = wr_n;
      ctrl_oe_next = ctrl_oe;
      data_oe_next = data_oe;
      grant_n_next = bus_grant_n;
      sel_next     = mem_space_selects;
      rdata_next   = rdata;
      rv_next      = rdata_valid;
      ws           = wait_states[req.space*WAIT_W +: WAIT_W];
      hung_n_next  = bus_grant_hung_n;
      ready_next   = req_ready;
      // pulses and grant-hung hold as well while the enable is low
      if (clk_en)
      begin
         rv_next     = 1'b0;
         ready_next  = 1'b0;
         hung_n_next = ~(~bus_grant_n & (req_valid | byte_dma_engine_need));
         unique case (st_reg)
            EMBG_IDLE:
               if (breq_reg)
               begin
                  ctrl_oe_next = 1'b0; // release first
                  sel_next     = `EMBG_SEL_IDLE;
                  st_next      = EMBG_RELEASE;
               end
               else if (req_valid)
               begin
                  cur_next   = req;
                  ready_next = 1'b1;
                  cnt_next   = {1'b0, ws};
                  sel_next   = ~(`EMBG_NUM_SPACES'(1) << req.space);
                  st_next    = EMBG_SETUP;
               end
            EMBG_SETUP:
            begin
               rd_n_next    = cur_reg.write;
               wr_n_next    = ~cur_reg.write;
               // data goes out with the falling strobe, so zero wait states still give setup
               data_oe_next = cur_reg.write;
               st_next      = EMBG_STROBE;
            end
            EMBG_STROBE:
            begin
               if (cnt_reg == '0)
               begin
                  rd_n_next = 1'b1;
                  wr_n_next = 1'b1;
                  if (!cur_reg.write)
                  begin
                     rdata_next = data_in;
                     rv_next    = 1'b1;
                  end
                  st_next = EMBG_HOLD;
               end
               else
                  cnt_next = cnt_reg - 1'b1;
            end
            EMBG_HOLD:
            begin
               data_oe_next = 1'b0; // before next strobe
               sel_next     = `EMBG_SEL_IDLE; // held past strobe rise
               st_next      = EMBG_IDLE;
            end
            EMBG_RELEASE:
            begin
               grant_n_next = 1'b0;
               st_next      = EMBG_GRANTED;
            end
            EMBG_GRANTED:
               if (!breq_reg)
               begin
                  grant_n_next = 1'b1; // grant high first
                  st_next      = EMBG_RESUME;
               end
            EMBG_RESUME:
            begin
               ctrl_oe_next = 1'b1;
               st_next      = EMBG_IDLE;
            end
            default:
               st_next = EMBG_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg            <= EMBG_IDLE;
         cur_reg           <= '0;
         cnt_reg           <= '0;
         rd_n              <= 1'b1;
         wr_n              <= 1'b1;
         ctrl_oe           <= 1'b1;
         data_oe           <= 1'b0;
         bus_grant_n       <= 1'b1;
         bus_grant_hung_n  <= 1'b1;
         mem_space_selects <= `EMBG_SEL_IDLE;
         req_ready         <= 1'b0;
         rdata_valid       <= 1'b0;
         rdata             <= '0;
         addr_out          <= '0;
         data_out          <= '0;
      end
      else
      begin
         st_reg            <= st_next;
         cur_reg           <= cur_next;
         cnt_reg           <= cnt_next;
         rd_n              <= rd_n_next;
         wr_n              <= wr_n_next;
         ctrl_oe           <= ctrl_oe_next;
         data_oe           <= data_oe_next;
         bus_grant_n       <= grant_n_next;
         bus_grant_hung_n  <= hung_n_next;
         mem_space_selects <= sel_next;
         req_ready         <= ready_next;
         rdata_valid       <= rv_next;
         rdata             <= rdata_next;
         addr_out          <= cur_next.addr; // cur_next already holds while the enable is low
         data_out          <= cur_next.wdata;
      end
   end

   property p_grant_after_release;
      @(posedge clk) disable iff (!rst_n)
      $fell(bus_grant_n) |-> !ctrl_oe && $past(!ctrl_oe);
   endproperty
   a_grant_after_release: assert property (p_grant_after_release) else $error("grant before release");
   property p_drive_after_ungrant;
      @(posedge clk) disable iff (!rst_n)
      $rose(ctrl_oe) |-> bus_grant_n && $past(bus_grant_n);
   endproperty
   a_drive_after_ungrant: assert property (p_drive_after_ungrant) else $error("driven while granted");
   property p_hung;
      @(posedge clk) disable iff (!rst_n)
      (clk_en && !bus_grant_n && byte_dma_engine_need) |=> !bus_grant_hung_n;
   endproperty
   a_hung: assert property (p_hung) else $error("hung not asserted");
   property p_rd_sel;
      @(posedge clk) disable iff (!rst_n)
      $fell(rd_n) |-> mem_space_selects != `EMBG_SEL_IDLE && $past(mem_space_selects) != `EMBG_SEL_IDLE;
   endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("select not set before read");
   property p_rd_hold;
      @(posedge clk) disable iff (!rst_n)
      $rose(rd_n) |-> mem_space_selects != `EMBG_SEL_IDLE;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("select dropped with strobe");
   property p_data_after_wr;
      @(posedge clk) disable iff (!rst_n)
      $rose(data_oe) |-> $fell(wr_n);
   endproperty
   a_data_after_wr: assert property (p_data_after_wr) else $error("data driven before strobe");
   property p_data_release;
      @(posedge clk) disable iff (!rst_n)
      $fell(rd_n) |-> !data_oe;
   endproperty
   a_data_release: assert property (p_data_release) else $error("data still driven at read");
   property p_wr_data_held;
      @(posedge clk) disable iff (!rst_n)
      $rose(wr_n) |-> data_oe;
   endproperty
   a_wr_data_held: assert property (p_wr_data_held) else $error("data gone at strobe rise");
   property p_strobe_len;
      @(posedge clk) disable iff (!rst_n)
      ($fell(wr_n) && clk_en && cnt_reg == '0) |=> wr_n;
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("zero-wait strobe too long");
   property p_irq_sync;
      @(posedge clk) disable iff (!rst_n)
      clk_en |=> irq_sync == $past(s2_reg[`EMBG_NUM_PF+1 +: `EMBG_NUM_IRQ]);
   endproperty
   a_irq_sync: assert property (p_irq_sync) else $error("interrupt not recognised");
endmodule
`default_nettype wire

/* tb/embg_mem_model.sv */
// memory partner for the external bus: answers reads, records writes
`timescale 1ns/100ps
`default_nettype none
module embg_mem_model
(
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [13:0] addr_out,
   input  wire logic [23:0] data_out,
   output logic      [23:0] data_in,
   output logic      [23:0] wr_data,
   output logic      [13:0] wr_addr
);
   logic [23:0] last = 24'h0;
   // read word follows the address; off the strobe the bus shows the
   // inverse of the last word, so a late sample never matches by chance
   always @(rd_n or addr_out)
   begin
      if (rd_n === 1'b0)
      begin
         data_in = {10'h2b5, addr_out};
         last = data_in;
      end
      else
         data_in = ~last;
   end
   // write word is taken at the rising strobe, the last moment it must hold
   always @(posedge wr_n)
   begin
      wr_data = data_out;
      wr_addr = addr_out;
   end
endmodule
`default_nettype wire

/* tb/ext_mem_bus_and_grant_test.sv */
// self-checking bench for the external memory bus and grant block
`timescale 1ns/100ps
`default_nettype none
module ext_mem_bus_and_grant_test
   import embg_pkg::*;
;
   logic        clk = 0, rst_n = 0, req_valid = 0, byte_dma_engine_need = 0, clk_en = 1;
   logic        bus_req_n = 1, flag_input = 0;
   embg_req_t   req = '0;
   logic [14:0] wait_states = 15'h4688; // space n gets n wait states
   logic [5:0]  ext_irq_lines = 6'h3f, irq_sync;
   logic [7:0]  prog_flag_pins = 8'h0, pf_sync;
   logic        req_ready, rdata_valid, rd_n, wr_n, ctrl_oe, data_oe;
   logic        bus_grant_n, bus_grant_hung_n, flag_sync;
   logic [23:0] rdata, data_out, data_in, wr_data;
   logic [13:0] addr_out, wr_addr;
   logic [4:0]  mem_space_selects;
   int          fail_count = 0, n_tests = 0, cyc = 0;

   always #2.5 clk = ~clk;

   embg_bus i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
      .req(req), .wait_states(wait_states), .byte_dma_engine_need(byte_dma_engine_need), .bus_req_n(bus_req_n),
      .ext_irq_lines(ext_irq_lines), .flag_input(flag_input),
      .prog_flag_pins(prog_flag_pins), .data_in(data_in), .req_ready(req_ready),
      .rdata_valid(rdata_valid), .rdata(rdata), .addr_out(addr_out),
      .mem_space_selects(mem_space_selects), .rd_n(rd_n), .wr_n(wr_n), .ctrl_oe(ctrl_oe),
      .data_out(data_out), .data_oe(data_oe), .bus_grant_n(bus_grant_n),
      .bus_grant_hung_n(bus_grant_hung_n), .irq_sync(irq_sync), .flag_sync(flag_sync),
      .pf_sync(pf_sync));

   embg_mem_model i_mem (.rd_n(rd_n), .wr_n(wr_n), .addr_out(addr_out),
      .data_out(data_out), .data_in(data_in), .wr_data(wr_data), .wr_addr(wr_addr));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // sample one step after the edge so the design's updates have landed
   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   // one memory cycle; strobe length, address and select hold are judged
   task automatic mem_cycle(input logic wr, input int sp, input logic [13:0] a,
                            input logic [23:0] d);
      int n;
      logic [4:0] sel;
      sel = ~(5'h1 << sp);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{write: wr, space: 3'(sp), addr: a, wdata: d};
      for (n = 0; n < 50 && req_ready !== 1'b1; n++)
         tick();
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      for (n = 0; n < 20 && (wr ? wr_n : rd_n) === 1'b0; n++)
      begin
         chk(24'(addr_out), 24'(a));
         chk(24'(mem_space_selects), 24'(sel));
         if (wr)
            chk(data_out, d);
         if (wr)
            chk(24'(data_oe), 24'h1);
         tick();
      end
      chk(24'(n), 24'(sp + 1));
      chk(24'(mem_space_selects), 24'(sel));
      if (wr)
         chk(wr_data, d);
      else
         chk(rdata, {10'h2b5, a});
      chk(24'(rdata_valid), 24'(!wr));
      repeat (2) tick();
      chk(24'(data_oe), 24'h0);
      chk(24'(mem_space_selects), 24'h1f);
      $display("test mem_cycle write=%0d space=%0d done", wr, sp);
   endtask

   // grant away, raise each bus need in turn, then take the bus back
   task automatic grant_test;
      int n;
      int k;
      @(posedge clk);
      bus_req_n <= 1'b0;
      #1;
      for (n = 0; n < 10 && ctrl_oe !== 1'b0; n++)
         tick();
      chk(24'(bus_grant_n), 24'h1);
      tick();
      chk(24'(bus_grant_n), 24'h0);
      for (k = 0; k < 2; k++)
      begin
         @(posedge clk);
         byte_dma_engine_need <= (k == 0);
         req_valid <= (k == 1);
         #1;
         for (n = 0; n < 4 && bus_grant_hung_n !== 1'b0; n++)
            tick();
         chk(24'(bus_grant_hung_n), 24'h0);
         chk(24'(req_ready), 24'h0);
         @(posedge clk);
         byte_dma_engine_need <= 1'b0;
         req_valid <= 1'b0;
         repeat (3) tick();
         chk(24'(bus_grant_hung_n), 24'h1);
      end
      @(posedge clk);
      bus_req_n <= 1'b1;
      #1;
      for (n = 0; n < 10 && bus_grant_n !== 1'b1; n++)
         tick();
      chk(24'(ctrl_oe), 24'h0);
      tick();
      chk(24'(ctrl_oe), 24'h1);
      $display("test grant done");
   endtask

   // raw inputs must appear exactly three edges later
   task automatic sync_test;
      @(posedge clk);
      ext_irq_lines <= 6'h2a; // held low until serviced
      flag_input <= 1'b1;
      prog_flag_pins <= 8'hc3;
      repeat (2) tick();
      chk(24'(irq_sync), 24'h3f);
      tick();
      chk(24'(irq_sync), 24'h2a);
      chk(24'(flag_sync), 24'h1);
      chk(24'(pf_sync), 24'hc3);
      $display("test sync done");
   endtask

   // a low enable must freeze the strobe, its wait count and the synchronisers
   task automatic freeze_test;
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{write: 1'b0, space: 3'h2, addr: 14'h1234, wdata: 24'h0};
      tick();
      @(posedge clk);
      req_valid <= 1'b0;
      clk_en <= 1'b0;
      ext_irq_lines <= 6'h15;
      repeat (6) tick();
      chk(24'(rd_n), 24'h0);
      chk(24'(irq_sync), 24'h2a);
      chk(24'(rdata_valid), 24'h0);
      @(posedge clk);
      clk_en <= 1'b1;
      #1;
      for (n = 0; n < 20 && rd_n === 1'b0; n++)
         tick();
      chk(24'(n), 24'h3);
      chk(rdata, {10'h2b5, 14'h1234});
      chk(24'(rdata_valid), 24'h1);
      chk(24'(irq_sync), 24'h15);
      $display("test freeze done");
   endtask

   // hang guard: the sequence needs well under this many cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         final_report();
      end
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int sp = 0; sp < 5; sp++)
      begin
         mem_cycle(1'b1, sp, 14'h3ff0 + 14'(sp), 24'ha5c3e0 ^ 24'(sp));
         mem_cycle(1'b0, sp, 14'h0010 + 14'(sp), 24'h0);
      end
      grant_test();
      mem_cycle(1'b0, 4, 14'h2abc, 24'h0);
      sync_test();
      freeze_test();
      final_report();
   end
endmodule
`default_nettype wire
